//--- core/mcrb_regs.svh
`ifndef MCRB_REGS_SVH
`define MCRB_REGS_SVH
`define MCRB_PTR_CFG 8'h00
`define MCRB_PTR_CAL 8'h05
`define MCRB_PTR_MASK 8'h06
`define MCRB_PTR_LIMIT 8'h07
`define MCRB_PTR_MAKER 8'hfe
`define MCRB_PTR_DIE 8'hff
`define MCRB_CFG_RESET 16'h4127
`define MCRB_ZERO16 16'h0000
`define MCRB_CFG_RST_BIT 15
`define MCRB_CFG_FIX_HI 14
`define MCRB_CFG_FIX_LO 12
`define MCRB_AVG_HI 11
`define MCRB_AVG_LO 9
`define MCRB_BCT_HI 8
`define MCRB_BCT_LO 6
`define MCRB_SCT_HI 5
`define MCRB_SCT_LO 3
`define MCRB_MODE_HI 2
`define MCRB_MODE_LO 0
`define MCRB_MODE_CONT_BIT 2
`endif

//--- core/mcrb_pkg.sv
package mcrb_pkg;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] ptr;
    logic [15:0] wdata;
  } mcrb_req_t;
  typedef struct packed {
    logic [2:0] sample_average_count;
    logic [2:0] bus_conversion_time;
    logic [2:0] shunt_conversion_time;
    logic [2:0] mode;
  } mcrb_cfg_t;
endpackage

//--- core/mcrb_bank.sv
`timescale 1ns/1ps
`include "mcrb_regs.svh"
// Operation
// RQ1: reading configuration changes nothing and leaves a running conversion alone
// RQ2: configuration write halts conversion, then restarts with new settings
// RQ3: writing one to config bit 15 resets all registers; bit self-clears
// RQ4: config bits 11:9 pick averaging 1,4,16,64,128,256,512,1024 samples
// RQ5: config bits 8:6 pick bus conversion time 140us to 8.244ms
// RQ6: shunt conversion time in bits 5:3, operating mode in bits 2:0
// RQ7: calibration register at 0x05, read/write, zero after reset
// RQ8: mask/enable register at 0x06, read/write, zero after reset
// RQ9: alert limit register at 0x07, read/write, zero after reset
// RQ10: read-only maker code at 0xfe, writes ignored
// RQ11: read-only die code at 0xff, writes ignored
// RQ12: configuration resets to 0x4127
// RQ13: mode 000/100 power down, 001-011 triggered, 101-111 continuous
// RQ14: current and power read zero while calibration is zero
// RQ15: config bits 14:12 ignore writes and read 100
// RQ16: host selects pointer, then moves two bytes, high byte first; here pointer and both bytes go in one request word
module mcrb_bank #(
  parameter logic [15:0] MAKER_CODE = 16'h1234, // arbitrary value
  parameter logic [15:0] DIE_CODE = 16'h5678 // arbitrary value
) (
  input wire clk_sys,
  input wire nrst,
  input wire mcrb_pkg::mcrb_req_t req,
  input wire conv_busy,
  input wire [15:0] raw_current,
  input wire [15:0] raw_power,
  output logic [15:0] rdata,
  output logic rvalid,
  output mcrb_pkg::mcrb_cfg_t cfg,
  output logic conv_halt,
  output logic conv_restart,
  output logic power_down,
  output logic continuous,
  output logic [15:0] cal_value,
  output logic [15:0] mask_value,
  output logic [15:0] limit_value,
  output logic [15:0] current_out,
  output logic [15:0] power_out,
  output logic soft_reset
);
  logic [15:0] cfg_r;
  logic [15:0] cal_r;
  logic [15:0] mask_r;
  logic [15:0] limit_r;
  logic [15:0] rdata_r;
  logic rvalid_r;
  logic restart_r;
  logic [15:0] cfg_nxt;
  logic [15:0] rdata_nxt;
  wire hit_cfg = req.ptr == `MCRB_PTR_CFG;
  wire hit_cal = req.ptr == `MCRB_PTR_CAL;
  wire hit_mask = req.ptr == `MCRB_PTR_MASK;
  wire hit_limit = req.ptr == `MCRB_PTR_LIMIT;
  wire hit_maker = req.ptr == `MCRB_PTR_MAKER;
  wire hit_die = req.ptr == `MCRB_PTR_DIE;
  wire wr_cfg = req.wr && hit_cfg;
  wire wr_cal = req.wr && hit_cal;
  wire wr_mask = req.wr && hit_mask;
  wire wr_limit = req.wr && hit_limit;
  wire rd_only = req.rd && !req.wr;
  wire hit_none = !(hit_cfg || hit_cal || hit_mask || hit_limit || hit_maker || hit_die);
  // full reset wins over any field write in the same access
  wire do_soft_rst = wr_cfg && req.wdata[`MCRB_CFG_RST_BIT]; // RQ3
  localparam logic [15:0] CFG_DEFAULT = `MCRB_CFG_RESET;
  wire [2:0] cfg_fixed = CFG_DEFAULT[`MCRB_CFG_FIX_HI:`MCRB_CFG_FIX_LO];
  // fixed bits 14:12 always from reset value; bit 15 never stored
  assign cfg_nxt = {1'b0, cfg_fixed, req.wdata[`MCRB_AVG_HI:`MCRB_MODE_LO]}; // RQ15 RQ6
  assign rdata_nxt = hit_cfg ? cfg_r :
    hit_cal ? cal_r :
    hit_mask ? mask_r :
    hit_limit ? limit_r :
    hit_maker ? MAKER_CODE : // RQ10
    hit_die ? DIE_CODE : // RQ11
    `MCRB_ZERO16;
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      cfg_r <= `MCRB_CFG_RESET; // RQ12
    else if (do_soft_rst)
      cfg_r <= `MCRB_CFG_RESET; // RQ3
    else if (wr_cfg)
      cfg_r <= cfg_nxt; // RQ2
  end
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      cal_r <= `MCRB_ZERO16;
    else if (do_soft_rst)
      cal_r <= `MCRB_ZERO16; // RQ3
    else if (wr_cal)
      cal_r <= req.wdata; // RQ7
  end
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      mask_r <= `MCRB_ZERO16;
    else if (do_soft_rst)
      mask_r <= `MCRB_ZERO16; // RQ3
    else if (wr_mask)
      mask_r <= req.wdata; // RQ8
  end
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      limit_r <= `MCRB_ZERO16;
    else if (do_soft_rst)
      limit_r <= `MCRB_ZERO16; // RQ3
    else if (wr_limit)
      limit_r <= req.wdata; // RQ9
  end
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      rdata_r <= `MCRB_ZERO16;
    else if (req.rd)
      rdata_r <= rdata_nxt; // RQ1
  end
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      rvalid_r <= 1'b0;
    else
      rvalid_r <= req.rd;
  end
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      restart_r <= 1'b0;
    else
      restart_r <= wr_cfg; // RQ2
  end
  assign rdata = rdata_r;
  assign rvalid = rvalid_r;
  assign cfg.sample_average_count = cfg_r[`MCRB_AVG_HI:`MCRB_AVG_LO]; // RQ4
  assign cfg.bus_conversion_time = cfg_r[`MCRB_BCT_HI:`MCRB_BCT_LO]; // RQ5
  assign cfg.shunt_conversion_time = cfg_r[`MCRB_SCT_HI:`MCRB_SCT_LO]; // RQ6
  assign cfg.mode = cfg_r[`MCRB_MODE_HI:`MCRB_MODE_LO];
  // halt lasts for the write cycle; the converter restarts next cycle
  assign conv_halt = wr_cfg; // RQ2
  assign conv_restart = restart_r; // RQ2
  assign power_down = cfg_r[`MCRB_MODE_HI - 1:`MCRB_MODE_LO] == 2'b00; // RQ13
  assign continuous = cfg_r[`MCRB_MODE_CONT_BIT] && !power_down; // RQ13
  assign cal_value = cal_r;
  assign mask_value = mask_r;
  assign limit_value = limit_r;
  // gated instead of relying on the arithmetic to produce zero
  assign current_out = (cal_r == `MCRB_ZERO16) ? `MCRB_ZERO16 : raw_current; // RQ14
  assign power_out = (cal_r == `MCRB_ZERO16) ? `MCRB_ZERO16 : raw_power; // RQ14
  assign soft_reset = do_soft_rst;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  cfg_read_safe_a: assert property ( // RQ1
    rd_only
    |=> $stable(cfg_r))
    else $error("config changed on read");
  read_no_halt_a: assert property ( // RQ1
    rd_only
    |-> !conv_halt)
    else $error("read halted the converter");
  cfg_read_a: assert property ( // RQ1
    (req.rd && hit_cfg)
    |=> rdata == $past(cfg_r))
    else $error("config read value wrong");
  rvalid_pulse_a: assert property ( // RQ1
    req.rd
    |=> rvalid)
    else $error("read not answered");
  rvalid_idle_a: assert property ( // RQ1
    !req.rd
    |=> !rvalid)
    else $error("answer without read");
  rdata_hold_a: assert property ( // RQ1
    !req.rd
    |=> $stable(rdata))
    else $error("read data moved without read");
  unmapped_read_a: assert property ( // RQ1
    (req.rd && hit_none)
    |=> rdata == `MCRB_ZERO16)
    else $error("unmapped read not zero");
  halt_restart_a: assert property ( // RQ2
    wr_cfg
    |-> conv_halt ##1 conv_restart)
    else $error("no restart after config write");
  halt_only_cfg_a: assert property ( // RQ2
    conv_halt
    |-> wr_cfg)
    else $error("halt without config write");
  restart_only_a: assert property ( // RQ2
    conv_restart
    |-> $past(wr_cfg))
    else $error("restart without config write");
  cfg_hold_a: assert property ( // RQ2
    !wr_cfg
    |=> $stable(cfg_r))
    else $error("config changed without write");
  soft_halt_a: assert property ( // RQ2
    do_soft_rst
    |-> conv_halt && soft_reset)
    else $error("full reset did not halt");
  soft_rst_a: assert property ( // RQ3
    do_soft_rst |=> cfg_r == `MCRB_CFG_RESET && cal_r == `MCRB_ZERO16
    && mask_r == `MCRB_ZERO16 && limit_r == `MCRB_ZERO16)
    else $error("soft reset incomplete");
  soft_rst_pulse_a: assert property ( // RQ3
    soft_reset
    |-> wr_cfg && req.wdata[`MCRB_CFG_RST_BIT])
    else $error("spurious full reset");
  rst_bit_clear_a: assert property ( // RQ3
    1'b1
    |-> !cfg_r[`MCRB_CFG_RST_BIT])
    else $error("reset bit stuck");
  avg_field_a: assert property ( // RQ4
    (wr_cfg && !do_soft_rst)
    |=> cfg.sample_average_count == $past(req.wdata[`MCRB_AVG_HI:`MCRB_AVG_LO]))
    else $error("averaging field wrong");
  bus_ct_a: assert property ( // RQ5
    (wr_cfg && !do_soft_rst)
    |=> cfg.bus_conversion_time == $past(req.wdata[`MCRB_BCT_HI:`MCRB_BCT_LO]))
    else $error("bus time field wrong");
  shunt_ct_a: assert property ( // RQ6
    (wr_cfg && !do_soft_rst)
    |=> cfg.shunt_conversion_time == $past(req.wdata[`MCRB_SCT_HI:`MCRB_SCT_LO]))
    else $error("shunt time field wrong");
  mode_field_a: assert property ( // RQ6
    (wr_cfg && !do_soft_rst)
    |=> cfg.mode == $past(req.wdata[`MCRB_MODE_HI:`MCRB_MODE_LO]))
    else $error("mode field wrong");
  cal_write_a: assert property ( // RQ7
    wr_cal
    |=> cal_value == $past(req.wdata))
    else $error("calibration not written");
  cal_hold_a: assert property ( // RQ7
    (!wr_cal && !do_soft_rst)
    |=> $stable(cal_r))
    else $error("calibration changed without write");
  cal_read_a: assert property ( // RQ7
    (req.rd && hit_cal)
    |=> rdata == $past(cal_r))
    else $error("calibration read wrong");
  mask_write_a: assert property ( // RQ8
    wr_mask
    |=> mask_value == $past(req.wdata))
    else $error("mask not written");
  mask_hold_a: assert property ( // RQ8
    (!wr_mask && !do_soft_rst)
    |=> $stable(mask_r))
    else $error("mask changed without write");
  mask_read_a: assert property ( // RQ8
    (req.rd && hit_mask)
    |=> rdata == $past(mask_r))
    else $error("mask read wrong");
  limit_write_a: assert property ( // RQ9
    wr_limit
    |=> limit_value == $past(req.wdata))
    else $error("limit not written");
  limit_hold_a: assert property ( // RQ9
    (!wr_limit && !do_soft_rst)
    |=> $stable(limit_r))
    else $error("limit changed without write");
  limit_read_a: assert property ( // RQ9
    (req.rd && hit_limit)
    |=> rdata == $past(limit_r))
    else $error("limit read wrong");
  maker_read_a: assert property ( // RQ10
    (req.rd && hit_maker)
    |=> rvalid && rdata == MAKER_CODE)
    else $error("maker code wrong");
  maker_write_a: assert property ( // RQ10
    (req.wr && hit_maker)
    |=> $stable(cfg_r) && $stable(cal_r) && $stable(mask_r) && $stable(limit_r))
    else $error("maker code write changed a register");
  die_read_a: assert property ( // RQ11
    (req.rd && hit_die)
    |=> rvalid && rdata == DIE_CODE)
    else $error("die code wrong");
  die_write_a: assert property ( // RQ11
    (req.wr && hit_die)
    |=> $stable(cfg_r) && $stable(cal_r) && $stable(mask_r) && $stable(limit_r))
    else $error("die code write changed a register");
  fixed_bits_a: assert property ( // RQ15
    1'b1
    |-> cfg_r[`MCRB_CFG_FIX_HI:`MCRB_CFG_FIX_LO] == cfg_fixed)
    else $error("fixed bits changed");
  pd_mode_a: assert property ( // RQ13
    1'b1
    |-> power_down == (cfg.mode == 3'h0 || cfg.mode == 3'h4))
    else $error("power down decode wrong");
  cont_mode_a: assert property ( // RQ13
    1'b1
    |-> continuous == (cfg.mode == 3'h5 || cfg.mode == 3'h6 || cfg.mode == 3'h7))
    else $error("continuous decode wrong");
  zero_cal_a: assert property ( // RQ14
    (cal_r == `MCRB_ZERO16)
    |-> current_out == `MCRB_ZERO16 && power_out == `MCRB_ZERO16)
    else $error("result nonzero with zero calibration");
  cal_pass_a: assert property ( // RQ14
    (cal_r != `MCRB_ZERO16)
    |-> current_out == raw_current && power_out == raw_power)
    else $error("result blocked with calibration set");
  // main scenarios
  cov_cfg_wr_c: cover property (wr_cfg ##1 conv_restart);
  cov_soft_rst_c: cover property (do_soft_rst);
  cov_cal_set_c: cover property (wr_cal && req.wdata != `MCRB_ZERO16);
  cov_id_rd_c: cover property (req.rd && hit_maker ##1 req.rd && hit_die);
  cov_busy_wr_c: cover property (conv_busy && wr_cfg);
endmodule

//--- dv/mcrb_host.sv
`timescale 1ns/1ps
module mcrb_host (
  input wire clk_sys,
  input wire [15:0] rdata,
  output mcrb_pkg::mcrb_req_t req
);
  initial req = '0;
  // pointer and both bytes go out as one word, high byte first
  task automatic go(input logic w, input logic [7:0] p, input logic [7:0] hi,
    input logic [7:0] lo, output logic [15:0] q);
    @(posedge clk_sys);
    #1 req = {w, ~w, p, hi, lo};
    @(posedge clk_sys);
    #1 q = rdata;
    req.wr = 1'b0;
    req.rd = 1'b0;
    // released data lines must not keep the last word
    req.wdata = ~req.wdata;
  endtask
endmodule

//--- dv/monitor_config_register_bank_bench.sv
`timescale 1ns/1ps
module monitor_config_register_bank_bench;
  logic clk_sys = 0;
  logic nrst = 0;
  int miscompares = 0;
  int checks = 0;
  int cycles = 0;
  logic [15:0] q, v, rdata, cal, cur;
  logic [2:0] c;
  logic restart, pdn, cont, rv, halt, srst;
  logic [15:0] mask, limit, pwr;
  int halts = 0;
  int softs = 0;
  mcrb_pkg::mcrb_req_t req;
  mcrb_pkg::mcrb_cfg_t cfg;
  mcrb_host host (.clk_sys(clk_sys), .rdata(rdata), .req(req));
  mcrb_bank dut (.clk_sys(clk_sys), .nrst(nrst), .req(req), .conv_busy(cont),
    .raw_current(16'hbeef), .raw_power(16'h1357), .rdata(rdata), .rvalid(rv), .cfg(cfg),
    .conv_halt(halt), .conv_restart(restart), .power_down(pdn), .continuous(cont),
    .cal_value(cal), .mask_value(mask), .limit_value(limit), .current_out(cur),
    .power_out(pwr), .soft_reset(srst));
  initial forever #2.5 clk_sys = ~clk_sys;
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    checks++;
    if (s !== e)
    begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic summarize;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic rd(input logic [7:0] p, input logic [15:0] e);
    host.go(1'b0, p, 8'h00, 8'h00, q);
    chk("rdata", q, e);
    chk("rvalid", {15'h0, rv}, 16'h0001);
  endtask
  // run is about 65 cycles; generous ceiling
  always @(posedge clk_sys)
  begin
    if (halt)
      halts++;
    if (srst)
      softs++;
    cycles++;
    if (cycles == 2000)
    begin
      miscompares++;
      summarize();
    end
  end
  initial
  begin
    repeat (5) @(posedge clk_sys);
    #1 nrst = 1;
    rd(8'h00, 16'h4127);
    chk("cfg", 16'(cfg), 16'h0127);
    rd(8'h05, 16'h0000);
    chk("current", cur, 16'h0000);
    chk("power", pwr, 16'h0000);
    rd(8'h06, 16'h0000);
    rd(8'h07, 16'h0000);
    host.go(1'b1, 8'h05, 8'hc3, 8'h5a, q);
    rd(8'h05, 16'hc35a);
    chk("current", cur, 16'hbeef);
    chk("power", pwr, 16'h1357);
    host.go(1'b1, 8'h06, 8'h81, 8'h7e, q);
    rd(8'h06, 16'h817e);
    chk("mask", mask, 16'h817e);
    host.go(1'b1, 8'h07, 8'hff, 8'hff, q);
    rd(8'h07, 16'hffff);
    chk("limit", limit, 16'hffff);
    host.go(1'b1, 8'hfe, 8'h00, 8'h00, q);
    rd(8'hfe, 16'h1234);
    host.go(1'b1, 8'hff, 8'h00, 8'h00, q);
    rd(8'hff, 16'h5678);
    rd(8'h08, 16'h0000);
    host.go(1'b1, 8'h00, 8'h7f, 8'hff, q);
    chk("restart", {15'h0, restart}, 16'h0001);
    rd(8'h00, 16'h4fff);
    chk("restart", {15'h0, restart}, 16'h0000);
    for (int i = 0; i < 8; i++)
    begin
      c = i[2:0];
      v = {4'h0, c, c, c, c};
      host.go(1'b1, 8'h00, v[15:8], v[7:0], q);
      chk("cfg", 16'(cfg), v);
      chk("pdn", {15'h0, pdn}, {15'h0, c[1:0] == 2'b00});
      chk("cont", {15'h0, cont}, {15'h0, c[2] && c[1:0] != 2'b00});
    end
    host.go(1'b1, 8'h00, 8'h80, 8'h00, q);
    rd(8'h00, 16'h4127);
    rd(8'h05, 16'h0000);
    rd(8'h06, 16'h0000);
    rd(8'h07, 16'h0000);
    chk("mask", mask, 16'h0000);
    chk("halts", 16'(halts), 16'h000a);
    chk("softs", 16'(softs), 16'h0001);
    summarize();
  end
endmodule
